/* File: rtl/drive_status_output_select.sv */
// Notes on behaviour
// RULE1: Code 9: on when output and reference zero
// RULE2: Code 10: on at upper frequency limit
// RULE3: Code 11: on at lower frequency limit
// RULE4: Code 12: on when powered, unprotected, runnable
// RULE5: Code 13: on during motor pre-excitation
// RULE6: Overload pre-alarm on after full delay
// RULE7: Code 15: underload pre-alarm after full delay
// RULE8: Code 16: pulse when program stage finishes
// RULE9: Code 17: pulse when program cycle finishes
// RULE10: Virtual terminal follows written bit, 1 on
// RULE11: Per-terminal code, routed every clock cycle
`timescale 1ns/1ps
`default_nettype none
module drive_status_output_select #(
    parameter int TICK_CYCLES = dso_pkg::TICK_CYCLES_DEF
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // Register port
    input wire logic [dso_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic [dso_pkg::DATA_W-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [dso_pkg::DATA_W-1:0] RDATA_O,
    // Drive conditions
    input wire logic [dso_pkg::FREQ_W-1:0] OUT_FREQ_I,
    input wire logic [dso_pkg::FREQ_W-1:0] REF_FREQ_I,
    input wire logic MAIN_PWR_OK_I,
    input wire logic CTRL_PWR_OK_I,
    input wire logic PROT_ACTIVE_I,
    input wire logic RUN_ABLE_I,
    input wire logic PREEXCITE_I,
    input wire logic OVERLOAD_I,
    input wire logic UNDERLOAD_I,
    input wire logic STAGE_DONE_I,
    input wire logic CYCLE_DONE_I,
    // Terminals and interrupt
    output logic [dso_pkg::NUM_TERM-1:0] DOUT_O,
    output logic IRQ_O
);
    import dso_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
    localparam logic [PULSE_W-1:0] PULSE_LEN = PULSE_W'(PLC_PULSE_CYCLES);

    // Configuration registers
    logic [CODE_W-1:0] sel_r [NUM_TERM];
    logic [CODE_W-1:0] sel_nxt [NUM_TERM];
    logic [NUM_TERM-1:0] vterm_r, vterm_nxt;
    logic [FREQ_W-1:0] uplim_r, uplim_nxt;
    logic [FREQ_W-1:0] lolim_r, lolim_nxt;
    logic [DLY_W-1:0] oldly_r, oldly_nxt;
    logic [DLY_W-1:0] uldly_r, uldly_nxt;
    logic [IRQ_W-1:0] imask_r, imask_nxt;
    logic [IRQ_W-1:0] istat_r, istat_nxt;
    logic [DATA_W-1:0] rdata_nxt;
    logic irq_nxt;

    // Condition state
    logic [COND_W-1:0] cond_r, cond_nxt;
    logic [TW-1:0] tick_cnt_r, tick_cnt_nxt;
    logic tick_r, tick_nxt;
    logic [PULSE_W-1:0] stg_cnt_r, stg_cnt_nxt;
    logic [PULSE_W-1:0] cyc_cnt_r, cyc_cnt_nxt;
    logic ovl_alarm, udl_alarm;
    logic ovl_d_r, udl_d_r;
    logic [IRQ_W-1:0] events;
    logic zero_in, ready_in;

    cond_if cif ();

    // Stretch counter: reload on a done pulse, else run down to zero
    function automatic logic [PULSE_W-1:0] stretch(input logic hit, input logic [PULSE_W-1:0] cnt);
        logic [PULSE_W-1:0] r;
        r = cnt;
        if (hit) begin
            r = PULSE_LEN;
        end else if (cnt != '0) begin
            r = cnt - 1'b1;
        end
        return r;
    endfunction

    assign zero_in = (OUT_FREQ_I == '0) && (REF_FREQ_I == '0);
    assign ready_in = MAIN_PWR_OK_I && CTRL_PWR_OK_I && !PROT_ACTIVE_I && RUN_ABLE_I;

    // Millisecond tick for the pre-alarm delays
    always_comb begin
        tick_nxt = (tick_cnt_r == TICK_LAST);
        tick_cnt_nxt = tick_nxt ? '0 : tick_cnt_r + 1'b1;
    end

    // Conditions sampled once per cycle so all terminals see the same snapshot
    always_comb begin
        stg_cnt_nxt = stretch(STAGE_DONE_I, stg_cnt_r); // RULE8
        cyc_cnt_nxt = stretch(CYCLE_DONE_I, cyc_cnt_r); // RULE9
        cond_nxt = '0;
        cond_nxt[C_ZERO] = zero_in; // RULE1
        cond_nxt[C_UPPER] = (OUT_FREQ_I >= uplim_r); // RULE2
        cond_nxt[C_LOWER] = (OUT_FREQ_I <= lolim_r); // RULE3
        cond_nxt[C_READY] = ready_in; // RULE4
        cond_nxt[C_PREEXC] = PREEXCITE_I; // RULE5
        cond_nxt[C_OVL] = ovl_alarm; // RULE6
        cond_nxt[C_UDL] = udl_alarm; // RULE7
        cond_nxt[C_STAGE] = STAGE_DONE_I || (stg_cnt_r != '0); // RULE8
        cond_nxt[C_CYCLE] = CYCLE_DONE_I || (cyc_cnt_r != '0); // RULE9
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
            stg_cnt_r <= '0;
            cyc_cnt_r <= '0;
            cond_r <= '0;
            ovl_d_r <= 1'b0;
            udl_d_r <= 1'b0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            tick_r <= tick_nxt;
            stg_cnt_r <= stg_cnt_nxt;
            cyc_cnt_r <= cyc_cnt_nxt;
            cond_r <= cond_nxt;
            ovl_d_r <= ovl_alarm;
            udl_d_r <= udl_alarm;
        end
    end

    // Pre-alarm delay timers, one per direction
    prealarm_timer u_ovl (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .cond_i(OVERLOAD_I),
        .tick_i(tick_r),
        .delay_i(oldly_r),
        .alarm_o(ovl_alarm)
    );

    prealarm_timer u_udl (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .cond_i(UNDERLOAD_I),
        .tick_i(tick_r),
        .delay_i(uldly_r),
        .alarm_o(udl_alarm)
    );

    // Virtual bits bypass the snapshot: one cycle from write to terminal
    assign cif.cond = cond_r;
    assign cif.vterm = vterm_r; // RULE10

    // One selector per terminal
    for (genvar t = 0; t < NUM_TERM; t++) begin : g_term
        term_mux #(.TERM(t)) u_mux (
            .clk_i(CLK_I),
            .rst_i(SYS_RST_I),
            .bus(cif),
            .sel_i(sel_r[t]),
            .do_o(DOUT_O[t])
        );
    end

    // Events for the interrupt status
    always_comb begin
        events = '0;
        events[I_OVL] = ovl_alarm && !ovl_d_r;
        events[I_UDL] = udl_alarm && !udl_d_r;
        events[I_STAGE] = STAGE_DONE_I;
        events[I_CYCLE] = CYCLE_DONE_I;
    end

    // Register writes, read data and clear-on-read; a new event beats the clear
    always_comb begin
        sel_nxt = sel_r;
        vterm_nxt = vterm_r;
        uplim_nxt = uplim_r;
        lolim_nxt = lolim_r;
        oldly_nxt = oldly_r;
        uldly_nxt = uldly_r;
        imask_nxt = imask_r;
        istat_nxt = istat_r;
        rdata_nxt = '0;
        if (WR_I) begin
            if (ADDR_I < A_VTERM) begin
                sel_nxt[ADDR_I[SEL_IDX_W-1:0]] = WDATA_I[CODE_W-1:0]; // RULE11
            end else if (ADDR_I == A_VTERM) begin
                vterm_nxt = WDATA_I[NUM_TERM-1:0]; // RULE10
            end else if (ADDR_I == A_UPLIM) begin
                uplim_nxt = WDATA_I[FREQ_W-1:0];
            end else if (ADDR_I == A_LOLIM) begin
                lolim_nxt = WDATA_I[FREQ_W-1:0];
            end else if (ADDR_I == A_OLDLY) begin
                oldly_nxt = WDATA_I[DLY_W-1:0];
            end else if (ADDR_I == A_ULDLY) begin
                uldly_nxt = WDATA_I[DLY_W-1:0];
            end else if (ADDR_I == A_IMASK) begin
                imask_nxt = WDATA_I[IRQ_W-1:0];
            end
        end
        if (RD_I) begin
            if (ADDR_I < A_VTERM) begin
                rdata_nxt[CODE_W-1:0] = sel_r[ADDR_I[SEL_IDX_W-1:0]];
            end else if (ADDR_I == A_VTERM) begin
                rdata_nxt[NUM_TERM-1:0] = vterm_r;
            end else if (ADDR_I == A_UPLIM) begin
                rdata_nxt[FREQ_W-1:0] = uplim_r;
            end else if (ADDR_I == A_LOLIM) begin
                rdata_nxt[FREQ_W-1:0] = lolim_r;
            end else if (ADDR_I == A_OLDLY) begin
                rdata_nxt[DLY_W-1:0] = oldly_r;
            end else if (ADDR_I == A_ULDLY) begin
                rdata_nxt[DLY_W-1:0] = uldly_r;
            end else if (ADDR_I == A_COND) begin
                rdata_nxt[COND_W-1:0] = cond_r;
            end else if (ADDR_I == A_DOUT) begin
                rdata_nxt[NUM_TERM-1:0] = DOUT_O;
            end else if (ADDR_I == A_ISTAT) begin
                rdata_nxt[IRQ_W-1:0] = istat_r;
                istat_nxt = '0;
            end else if (ADDR_I == A_IMASK) begin
                rdata_nxt[IRQ_W-1:0] = imask_r;
            end
        end
        istat_nxt = istat_nxt | events;
        irq_nxt = |(istat_nxt & imask_nxt);
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            for (int i = 0; i < NUM_TERM; i++) begin
                sel_r[i] <= RST_SEL;
            end
            vterm_r <= '0;
            uplim_r <= RST_UPLIM;
            lolim_r <= RST_LOLIM;
            oldly_r <= RST_DLY;
            uldly_r <= RST_DLY;
            imask_r <= '0;
            istat_r <= '0;
            RDATA_O <= '0;
            IRQ_O <= 1'b0;
        end else begin
            sel_r <= sel_nxt;
            vterm_r <= vterm_nxt;
            uplim_r <= uplim_nxt;
            lolim_r <= lolim_nxt;
            oldly_r <= oldly_nxt;
            uldly_r <= uldly_nxt;
            imask_r <= imask_nxt;
            istat_r <= istat_nxt;
            RDATA_O <= rdata_nxt;
            IRQ_O <= irq_nxt;
        end
    end

    default clocking @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);

    // Per-terminal checks: code held over the two-stage path
    sequence code_held(int t, logic [CODE_W-1:0] fc);
        (sel_r[t] == fc) && ($past(sel_r[t]) == fc);
    endsequence

    sequence stage_held;
        cond_r[C_STAGE] [*8];
    endsequence

    sequence cycle_held;
        cond_r[C_CYCLE] [*8];
    endsequence

    zero_speed_a: assert property (code_held(0, FC_ZERO_SPEED) |-> DOUT_O[0] == $past(zero_in, 2)) // RULE1
        else $error("zero speed terminal mismatch");
    upper_lim_a: assert property (code_held(1, FC_UPPER_LIM) |-> DOUT_O[1] == $past(OUT_FREQ_I >= uplim_r, 2)) // RULE2
        else $error("upper limit terminal mismatch");
    lower_lim_a: assert property (code_held(2, FC_LOWER_LIM) |-> DOUT_O[2] == $past(OUT_FREQ_I <= lolim_r, 2)) // RULE3
        else $error("lower limit terminal mismatch");
    ready_out_a: assert property (code_held(3, FC_READY) |-> DOUT_O[3] == $past(ready_in, 2)) // RULE4
        else $error("ready terminal mismatch");
    preexc_hold_a: assert property (code_held(0, FC_PREEXC) |-> DOUT_O[0] == $past(PREEXCITE_I, 2)) // RULE5
        else $error("pre-excitation terminal mismatch");
    overload_out_a: assert property (code_held(0, FC_OVERLOAD) |-> DOUT_O[0] == $past(ovl_alarm, 2)) // RULE6
        else $error("overload terminal mismatch");
    underload_out_a: assert property (code_held(3, FC_UNDERLOAD) ##0 DOUT_O[3] |-> $past(UNDERLOAD_I, 3)) // RULE7
        else $error("underload terminal on without condition");
    stage_pulse_a: assert property (STAGE_DONE_I |=> stage_held) // RULE8
        else $error("stage done not held");
    cycle_pulse_a: assert property (CYCLE_DONE_I |=> cycle_held) // RULE9
        else $error("cycle done not held");
    vterm_out_a: assert property (code_held(0, FC_VTERM) |-> DOUT_O[0] == $past(vterm_r[0])) // RULE10
        else $error("virtual terminal mismatch");
    unused_code_a: assert property ((sel_r[0] < FC_ZERO_SPEED) |=> !DOUT_O[0]) // RULE11
        else $error("unsupported code drove terminal");
    irq_level_a: assert property (IRQ_O == $past(|(istat_nxt & imask_nxt)))
        else $error("interrupt level mismatch");
endmodule
`default_nettype wire

/* File: rtl/dso_pkg.sv */
package dso_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS = 1000000;
    localparam int TICK_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
    localparam int PLC_PULSE_NS = 100000;
    localparam int PLC_PULSE_CYCLES = PLC_PULSE_NS / CLK_PERIOD_NS;
    localparam int PULSE_W = 12;

    // Widths
    localparam int NUM_TERM = 4;
    localparam int SEL_IDX_W = 2;
    localparam int CODE_W = 5;
    localparam int FREQ_W = 16;
    localparam int DLY_W = 16;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // Output function codes
    localparam logic [CODE_W-1:0] FC_ZERO_SPEED = 5'h09;
    localparam logic [CODE_W-1:0] FC_UPPER_LIM = 5'h0A;
    localparam logic [CODE_W-1:0] FC_LOWER_LIM = 5'h0B;
    localparam logic [CODE_W-1:0] FC_READY = 5'h0C;
    localparam logic [CODE_W-1:0] FC_PREEXC = 5'h0D;
    localparam logic [CODE_W-1:0] FC_OVERLOAD = 5'h0E;
    localparam logic [CODE_W-1:0] FC_UNDERLOAD = 5'h0F;
    localparam logic [CODE_W-1:0] FC_STAGE_DONE = 5'h10;
    localparam logic [CODE_W-1:0] FC_CYCLE_DONE = 5'h11;
    localparam logic [CODE_W-1:0] FC_VTERM = 5'h12;

    // Condition vector bit positions
    localparam int C_ZERO = 0;
    localparam int C_UPPER = 1;
    localparam int C_LOWER = 2;
    localparam int C_READY = 3;
    localparam int C_PREEXC = 4;
    localparam int C_OVL = 5;
    localparam int C_UDL = 6;
    localparam int C_STAGE = 7;
    localparam int C_CYCLE = 8;
    localparam int COND_W = 9;

    // Interrupt status bits
    localparam int I_OVL = 0;
    localparam int I_UDL = 1;
    localparam int I_STAGE = 2;
    localparam int I_CYCLE = 3;
    localparam int IRQ_W = 4;

    // Register word addresses
    localparam logic [ADDR_W-1:0] A_SEL0 = 4'h0;
    localparam logic [ADDR_W-1:0] A_VTERM = 4'h4;
    localparam logic [ADDR_W-1:0] A_UPLIM = 4'h5;
    localparam logic [ADDR_W-1:0] A_LOLIM = 4'h6;
    localparam logic [ADDR_W-1:0] A_OLDLY = 4'h7;
    localparam logic [ADDR_W-1:0] A_ULDLY = 4'h8;
    localparam logic [ADDR_W-1:0] A_COND = 4'h9;
    localparam logic [ADDR_W-1:0] A_DOUT = 4'hA;
    localparam logic [ADDR_W-1:0] A_ISTAT = 4'hB;
    localparam logic [ADDR_W-1:0] A_IMASK = 4'hC;

    // Reset values
    localparam logic [CODE_W-1:0] RST_SEL = 5'h00;
    localparam logic [FREQ_W-1:0] RST_UPLIM = 16'hFFFF;
    localparam logic [FREQ_W-1:0] RST_LOLIM = 16'h0000;
    localparam logic [DLY_W-1:0] RST_DLY = 16'h0000;
endpackage

/* File: rtl/cond_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cond_if;
    import dso_pkg::*;
    logic [COND_W-1:0] cond;
    logic [NUM_TERM-1:0] vterm;
    modport src (output cond, output vterm);
    modport dst (input cond, input vterm);
endinterface
`default_nettype wire

/* File: rtl/prealarm_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module prealarm_timer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Condition and timing
    input wire logic cond_i,
    input wire logic tick_i,
    input wire logic [dso_pkg::DLY_W-1:0] delay_i,
    // Result
    output logic alarm_o
);
    import dso_pkg::*;

    logic [DLY_W:0] cnt_r, cnt_nxt;
    logic alarm_nxt;

    // Count whole ms ticks while over threshold; strict compare covers tick phase
    always_comb begin
        cnt_nxt = cnt_r;
        if (!cond_i) begin
            cnt_nxt = '0;
        end else if (tick_i && !(&cnt_r)) begin
            cnt_nxt = cnt_r + 1'b1;
        end
        alarm_nxt = cond_i && ((delay_i == '0) || (cnt_r > {1'b0, delay_i})); // RULE6 RULE7
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            alarm_o <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            alarm_o <= alarm_nxt;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    alarm_cause_a: assert property (alarm_o |-> $past(cond_i)) // RULE6
        else $error("pre-alarm on without condition");
    alarm_wait_a: assert property ($rose(alarm_o) |-> ($past(delay_i) == '0) || // RULE7
        ($past(cnt_r) > {1'b0, $past(delay_i)}))
        else $error("pre-alarm rose before delay elapsed");
endmodule
`default_nettype wire

/* File: rtl/term_mux.sv */
`timescale 1ns/1ps
`default_nettype none
module term_mux #(
    parameter int TERM = 0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Conditions and selection
    cond_if.dst bus,
    input wire logic [dso_pkg::CODE_W-1:0] sel_i,
    // Terminal
    output logic do_o
);
    import dso_pkg::*;

    logic do_nxt;

    // Codes outside the supported set drive the terminal off
    function automatic logic pick(input logic [CODE_W-1:0] code, input logic [COND_W-1:0] c, input logic v);
        logic r;
        r = 1'b0;
        unique case (code)
            FC_ZERO_SPEED: r = c[C_ZERO];
            FC_UPPER_LIM: r = c[C_UPPER];
            FC_LOWER_LIM: r = c[C_LOWER];
            FC_READY: r = c[C_READY];
            FC_PREEXC: r = c[C_PREEXC];
            FC_OVERLOAD: r = c[C_OVL];
            FC_UNDERLOAD: r = c[C_UDL];
            FC_STAGE_DONE: r = c[C_STAGE];
            FC_CYCLE_DONE: r = c[C_CYCLE];
            FC_VTERM: r = v;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Route every cycle
    always_comb begin
        do_nxt = pick(sel_i, bus.cond, bus.vterm[TERM]); // RULE11
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            do_o <= 1'b0;
        end else begin
            do_o <= do_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: bench/status_reader.sv */
`timescale 1ns/1ps
`default_nettype none
module status_reader (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Terminals as the controller sees them
    input wire logic [dso_pkg::NUM_TERM-1:0] dout_i,
    // Length of the last ON period per terminal
    output logic [dso_pkg::NUM_TERM-1:0][15:0] on_len_o
);
    import dso_pkg::*;
    logic [NUM_TERM-1:0][15:0] run_r, run_nxt, len_nxt;

    // Count ON cycles, latch the count when a terminal drops
    always_comb begin
        run_nxt = run_r;
        len_nxt = on_len_o;
        for (int i = 0; i < NUM_TERM; i++) begin
            if (dout_i[i]) begin
                run_nxt[i] = run_r[i] + 16'h0001;
            end else begin
                if (run_r[i] != 16'h0000) begin
                    len_nxt[i] = run_r[i];
                end
                run_nxt[i] = 16'h0000;
            end
        end
    end

    // Registered so a glitch-free level is all it needs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_r <= '0;
            on_len_o <= '0;
        end else begin
            run_r <= run_nxt;
            on_len_o <= len_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: bench/drive_status_output_select_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module drive_status_output_select_tb_top;
    import dso_pkg::*;
    localparam int TICKS = 4;
    logic CLK_I = 1'b0, SYS_RST_I = 1'b1, WR_I = 1'b0, RD_I = 1'b0;
    logic [ADDR_W-1:0] ADDR_I = '0;
    logic [DATA_W-1:0] WDATA_I = '0, RDATA_O, rv;
    logic [FREQ_W-1:0] OUT_FREQ_I = '0, REF_FREQ_I = '0;
    logic MAIN_PWR_OK_I = 1'b0, CTRL_PWR_OK_I = 1'b0, PROT_ACTIVE_I = 1'b0, RUN_ABLE_I = 1'b0;
    logic PREEXCITE_I = 1'b0, OVERLOAD_I = 1'b0, UNDERLOAD_I = 1'b0;
    logic STAGE_DONE_I = 1'b0, CYCLE_DONE_I = 1'b0, IRQ_O;
    logic [NUM_TERM-1:0] DOUT_O;
    logic [NUM_TERM-1:0][15:0] on_len;
    int failures = 0, checked = 0;

    // 20 MHz clock
    always #25 CLK_I = ~CLK_I;

    drive_status_output_select #(.TICK_CYCLES(TICKS)) dut (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
        .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
        .OUT_FREQ_I(OUT_FREQ_I), .REF_FREQ_I(REF_FREQ_I), .MAIN_PWR_OK_I(MAIN_PWR_OK_I),
        .CTRL_PWR_OK_I(CTRL_PWR_OK_I), .PROT_ACTIVE_I(PROT_ACTIVE_I), .RUN_ABLE_I(RUN_ABLE_I),
        .PREEXCITE_I(PREEXCITE_I), .OVERLOAD_I(OVERLOAD_I), .UNDERLOAD_I(UNDERLOAD_I),
        .STAGE_DONE_I(STAGE_DONE_I), .CYCLE_DONE_I(CYCLE_DONE_I), .DOUT_O(DOUT_O), .IRQ_O(IRQ_O));

    status_reader reader (.clk_i(CLK_I), .rst_i(SYS_RST_I), .dout_i(DOUT_O), .on_len_o(on_len));

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle strobes, data taken at the next edge
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge CLK_I);
        WR_I <= 1'b1;
        ADDR_I <= a;
        WDATA_I <= d;
        @(posedge CLK_I);
        WR_I <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge CLK_I);
        RD_I <= 1'b1;
        ADDR_I <= a;
        @(posedge CLK_I);
        RD_I <= 1'b0;
        #1 d = RDATA_O;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge CLK_I);
        #1;
    endtask

    // Bounded wait for a terminal level; running out ends the run
    task automatic wait_term(input int i, input logic v, input int lim);
        for (int n = 0; n < lim; n++) begin
            settle(1);
            if (DOUT_O[i] === v) return;
        end
        failures++;
        $display("ERROR wait_term %0d expected %b", i, v);
        report_and_stop();
    endtask

    task automatic t_reset();
        rd(A_SEL0, rv);
        check("sel0", rv, 32'h0000_0000);
        settle(1);
        check("rdata drop", RDATA_O, 32'h0000_0000);
        rd(A_UPLIM, rv);
        check("uplim", rv, 32'h0000_FFFF);
        rd(A_LOLIM, rv);
        check("lolim", rv, 32'h0000_0000);
        check("dout idle", {28'h0, DOUT_O}, 32'h0000_0000);
        wr(4'hD, 32'h0000_00FF);
        rd(4'hD, rv);
        check("unmapped", rv, 32'h0000_0000);
    endtask

    task automatic t_zero();
        wr(A_SEL0, {27'h0, FC_ZERO_SPEED});
        REF_FREQ_I <= 16'h0005;
        settle(4);
        check("zero ref", {31'h0, DOUT_O[0]}, 32'h0);
        REF_FREQ_I <= 16'h0000;
        OUT_FREQ_I <= 16'h0003;
        settle(4);
        check("zero out", {31'h0, DOUT_O[0]}, 32'h0);
        OUT_FREQ_I <= 16'h0000;
        settle(4);
        check("zero both", {31'h0, DOUT_O[0]}, 32'h1);
    endtask

    task automatic t_limits();
        logic [15:0] fq [5] = '{16'h0064, 16'h000A, 16'h0032, 16'h0063, 16'h000B};
        wr(A_UPLIM, 32'h0000_0064);
        wr(A_LOLIM, 32'h0000_000A);
        wr(A_SEL0 + 4'h1, {27'h0, FC_UPPER_LIM});
        wr(A_SEL0 + 4'h2, {27'h0, FC_LOWER_LIM});
        foreach (fq[k]) begin
            OUT_FREQ_I <= fq[k];
            settle(4);
            check("upper", {31'h0, DOUT_O[1]}, {31'h0, fq[k] >= 16'h0064});
            check("lower", {31'h0, DOUT_O[2]}, {31'h0, fq[k] <= 16'h000A});
        end
    endtask

    task automatic t_ready();
        logic [3:0] v;
        wr(A_SEL0 + 4'h3, {27'h0, FC_READY});
        for (int k = 0; k < 16; k++) begin
            v = 4'(k);
            {MAIN_PWR_OK_I, CTRL_PWR_OK_I, PROT_ACTIVE_I, RUN_ABLE_I} <= v;
            settle(4);
            check("ready", {31'h0, DOUT_O[3]}, {31'h0, v == 4'hD});
        end
    endtask

    // Exact two-edge latency from the condition input
    task automatic t_preexc();
        wr(A_SEL0, {27'h0, FC_PREEXC});
        @(posedge CLK_I);
        PREEXCITE_I <= 1'b1;
        settle(1);
        check("preexc c1", {31'h0, DOUT_O[0]}, 32'h0);
        settle(1);
        check("preexc c2", {31'h0, DOUT_O[0]}, 32'h1);
        settle(20);
        check("preexc hold", {31'h0, DOUT_O[0]}, 32'h1);
        PREEXCITE_I <= 1'b0;
        settle(4);
        check("preexc off", {31'h0, DOUT_O[0]}, 32'h0);
    endtask

    // Delay of 2 ticks: no alarm before two full ticks, alarm within two more
    task automatic t_overload();
        wr(A_IMASK, 32'h0000_0001);
        rd(A_ISTAT, rv);
        wr(A_OLDLY, 32'h0000_0002);
        wr(A_SEL0, {27'h0, FC_OVERLOAD});
        @(posedge CLK_I);
        OVERLOAD_I <= 1'b1;
        settle(2 * TICKS);
        check("ovl early", {31'h0, DOUT_O[0]}, 32'h0);
        wait_term(0, 1'b1, 2 * TICKS);
        settle(2);
        check("irq set", {31'h0, IRQ_O}, 32'h1);
        rd(A_ISTAT, rv);
        check("istat ovl", rv, 32'h0000_0001);
        rd(A_ISTAT, rv);
        check("istat clr", rv, 32'h0000_0000);
        settle(2);
        check("irq clr", {31'h0, IRQ_O}, 32'h0);
        OVERLOAD_I <= 1'b0;
        wait_term(0, 1'b0, 4);
    endtask

    task automatic t_underload();
        wr(A_ULDLY, 32'h0000_0000);
        wr(A_SEL0 + 4'h3, {27'h0, FC_UNDERLOAD});
        settle(4);
        check("udl idle", {31'h0, DOUT_O[3]}, 32'h0);
        UNDERLOAD_I <= 1'b1;
        wait_term(3, 1'b1, 4);
        rd(A_COND, rv);
        check("cond udl", rv, 32'h0000_0040);
        // Delay of 1 tick: no alarm within one tick, alarm within two more
        @(posedge CLK_I);
        UNDERLOAD_I <= 1'b0;
        wait_term(3, 1'b0, 4);
        wr(A_ULDLY, 32'h0000_0001);
        @(posedge CLK_I);
        UNDERLOAD_I <= 1'b1;
        settle(TICKS);
        check("udl early", {31'h0, DOUT_O[3]}, 32'h0);
        wait_term(3, 1'b1, 2 * TICKS);
    endtask

    // Stretched pulse, status bit masked so the interrupt stays low
    task automatic t_stage();
        rd(A_ISTAT, rv);
        wr(A_SEL0 + 4'h1, {27'h0, FC_STAGE_DONE});
        STAGE_DONE_I <= 1'b1;
        @(posedge CLK_I);
        STAGE_DONE_I <= 1'b0;
        wait_term(1, 1'b1, 4);
        settle(3);
        check("irq masked", {31'h0, IRQ_O}, 32'h0);
        wait_term(1, 1'b0, PLC_PULSE_CYCLES + 8);
        settle(1);
        check("stage len", {16'h0, on_len[1]}, PLC_PULSE_CYCLES + 1);
    endtask

    task automatic t_cycle();
        wr(A_SEL0 + 4'h2, {27'h0, FC_CYCLE_DONE});
        wr(A_IMASK, 32'h0000_0008);
        CYCLE_DONE_I <= 1'b1;
        @(posedge CLK_I);
        CYCLE_DONE_I <= 1'b0;
        wait_term(2, 1'b1, 4);
        settle(2);
        check("irq cycle", {31'h0, IRQ_O}, 32'h1);
        rd(A_ISTAT, rv);
        check("istat sc", rv, 32'h0000_000C);
        settle(2);
        check("irq off", {31'h0, IRQ_O}, 32'h0);
    endtask

    task automatic t_vterm();
        for (int i = 0; i < NUM_TERM; i++) begin
            wr(A_SEL0 + ADDR_W'(i), {27'h0, FC_VTERM});
        end
        wr(A_VTERM, 32'h0000_0005);
        settle(2);
        check("vterm 5", {28'h0, DOUT_O}, 32'h0000_0005);
        wr(A_VTERM, 32'h0000_000A);
        settle(2);
        rd(A_DOUT, rv);
        check("vterm A", rv, 32'h0000_000A);
    endtask

    // Reset for 3 cycles, then the scenarios in turn
    initial begin
        repeat (3) @(posedge CLK_I);
        SYS_RST_I <= 1'b0;
        t_reset();
        t_zero();
        t_limits();
        t_ready();
        t_preexc();
        t_overload();
        t_underload();
        t_stage();
        t_cycle();
        t_vterm();
        report_and_stop();
    end
endmodule
`default_nettype wire
